//--- rtl/cbx_exec.sv
// Purpose: execute compressed trap, branch and long branch with link
// Assumes: fetch gives opcode with its own address; register file holds link
// Notes: one instruction at a time, busy holds off the fetch stage
`timescale 1ns/100ps
module cbx_exec
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire cbx_pkg::cbx_fetch_t fetch,
    output logic fetch_ready,
    input wire logic [31:0] link_register,
    input wire logic [31:0] current_program_status,
    output cbx_pkg::cbx_wb_t wb,
    output logic busy
);
    typedef enum logic [1:0]
    {
        CBX_IDLE = 2'b00,
        CBX_WAIT = 2'b01
    } cbx_state_t;

    cbx_pkg::cbx_op_t op;
    logic [10:0] branch_offset_field;
    cbx_state_t state;
    cbx_state_t next_state;
    logic [1:0] cnt;
    logic [1:0] next_cnt;
    cbx_pkg::cbx_wb_t next_wb;
    logic [31:0] base;
    logic [31:0] next_addr;
    logic [31:0] br_target;
    logic [31:0] upper_sum;
    logic [31:0] lower_sum;
    logic take;

    // classification by prefix only, no history between halves
    cbx_decode u_decode
    (
        .opcode(fetch.opcode),
        .op(op),
        .offset_field(branch_offset_field)
    );

    // both signed branch forms widen the offset field the same way
    function automatic logic [31:0] sext_offset
    (
        input logic [10:0] field
    );
        sext_offset = {{(cbx_pkg::ADDR_W - cbx_pkg::OFFSET_W){field[cbx_pkg::OFFSET_W-1]}},
            field};
    endfunction

    // base and target arithmetic
    always_comb
    begin
        base = fetch.addr + cbx_pkg::PREFETCH_OFS;
        next_addr = fetch.addr + cbx_pkg::HALF_STEP;
        // sign-extend 11 bits, shift one: 12-bit offset, bit 0 zero
        br_target = base + (sext_offset(branch_offset_field) << cbx_pkg::LOW_SHIFT);
        // upper part shifted by 12 gives the top of the 23-bit offset
        upper_sum = base + (sext_offset(branch_offset_field) << cbx_pkg::HIGH_SHIFT);
        // lower part is unsigned and reuses link as its base
        lower_sum = link_register + {20'h00000, branch_offset_field, 1'b0};
    end

    assign take = fetch.valid && (state == CBX_IDLE) && (op != cbx_pkg::CBX_OP_NONE);
    assign fetch_ready = (state == CBX_IDLE);
    assign busy = (state != CBX_IDLE);

    // next write-back and stall counter
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_wb = '0;
        if (state == CBX_WAIT)
        begin
            next_cnt = cnt - 2'h1;
            if (cnt == 2'h1)
                next_state = CBX_IDLE;
        end
        else if (take)
        begin
            case (op)
                cbx_pkg::CBX_OP_TRAP:
                begin
                    // immediate bits [7:0] never reach any trap write-back field
                    next_wb.lr_we = 1'b1;
                    next_wb.lr = next_addr;
                    next_wb.saved_program_status_we = 1'b1;
                    next_wb.saved_psr = current_program_status;
                    next_wb.pc_we = 1'b1;
                    next_wb.pc = cbx_pkg::TRAP_VECTOR;
                    next_wb.psr_we = 1'b1;
                    next_wb.cur_psr = current_program_status;
                    next_wb.cur_psr[cbx_pkg::STATE_BIT] = 1'b0;
                    next_wb.cur_psr[cbx_pkg::IRQ_MASK_BIT] = 1'b1;
                    next_wb.cur_psr[cbx_pkg::MODE_LSB +: cbx_pkg::MODE_W] =
                        cbx_pkg::SUPERVISOR_MODE;
                    next_cnt = 2'(cbx_pkg::TRAP_CYCLES - 1);
                end
                cbx_pkg::CBX_OP_BRANCH:
                begin
                    next_wb.pc_we = 1'b1;
                    next_wb.pc = br_target;
                    next_cnt = 2'(cbx_pkg::BR_CYCLES - 1);
                end
                cbx_pkg::CBX_OP_LBL_HIGH:
                begin
                    next_wb.lr_we = 1'b1;
                    next_wb.lr = upper_sum;
                    next_cnt = 2'(cbx_pkg::LBL_HIGH_CYCLES - 1);
                end
                cbx_pkg::CBX_OP_LBL_LOW:
                begin
                    next_wb.pc_we = 1'b1;
                    next_wb.pc = lower_sum;
                    next_wb.lr_we = 1'b1;
                    next_wb.lr = {next_addr[31:1], 1'b1};
                    next_cnt = 2'(cbx_pkg::LBL_LOW_CYCLES - 1);
                end
                default:
                begin
                    next_cnt = cnt;
                end
            endcase
            if (next_cnt != 2'h0)
                next_state = CBX_WAIT;
        end
    end

    // registers only
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= CBX_IDLE;
            cnt <= 2'h0;
            wb <= '0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            wb <= next_wb;
        end
    end

    // one strobe per taken class keeps the checks below short
    logic take_trap;
    logic take_br;
    logic take_upper;
    logic take_lower;
    assign take_trap = take && (op == cbx_pkg::CBX_OP_TRAP);
    assign take_br = take && (op == cbx_pkg::CBX_OP_BRANCH);
    assign take_upper = take && (op == cbx_pkg::CBX_OP_LBL_HIGH);
    assign take_lower = take && (op == cbx_pkg::CBX_OP_LBL_LOW);

    // helper: length of the running stall, so a stuck busy shows up at once
    logic [2:0] busy_run;
    logic [2:0] next_busy_run;
    always_comb
    begin
        next_busy_run = busy ? busy_run + 3'h1 : 3'h0;
    end
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            busy_run <= 3'h0;
        else
            busy_run <= next_busy_run;
    end

    // trap write-back is fixed vector, supervisor mode
    chk_trap_vector: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_trap |=> wb.pc_we && wb.pc == 32'h0000_0008)
        else $error("trap vector wrong");
    chk_trap_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_trap |=> wb.psr_we && wb.cur_psr[4:0] == 5'h13 && !wb.cur_psr[5])
        else $error("trap mode wrong");
    // only mode, state and mask may change; a lost flag would corrupt the handler
    chk_trap_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_trap |=> wb.cur_psr[31:8] == $past(current_program_status[31:8])
        && wb.cur_psr[6] == $past(current_program_status[6]) && wb.cur_psr[7])
        else $error("trap status bits wrong");
    chk_trap_save: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_trap |=> wb.saved_program_status_we && wb.lr_we
        && wb.saved_psr == $past(current_program_status)
        && wb.lr == $past(fetch.addr) + 32'h2)
        else $error("trap save wrong");
    chk_trap_imm: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_trap |=> wb.pc == 32'h8)
        else $error("trap immediate leaked");
    chk_trap_cycles: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_trap |=> busy [*2] ##1 !busy)
        else $error("trap cycle count wrong");
    chk_stall_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
        busy_run <= 3'h2)
        else $error("stall too long");

    // branch: signed halfword offset from the prefetch base
    chk_branch_target: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_br |=> wb.pc == $past(fetch.addr) + 32'h4
        + {{20{$past(fetch.opcode[10])}}, $past(fetch.opcode[10:0]), 1'b0})
        else $error("branch target wrong");
    chk_branch_reach: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_br |=> wb.pc - $past(fetch.addr) + 32'h7FC < 32'h1000)
        else $error("branch out of reach");
    chk_branch_back: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_br && fetch.opcode[10] |=> wb.pc - $past(fetch.addr) - 32'h4 >= 32'hFFFF_F800)
        else $error("backward branch wrong");
    chk_branch_fwd: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_br && !fetch.opcode[10] |=> wb.pc - $past(fetch.addr) - 32'h4 <= 32'h0000_07FE)
        else $error("forward branch wrong");
    chk_branch_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_br |=> wb.pc_we && !wb.lr_we && !wb.psr_we && !wb.saved_program_status_we)
        else $error("branch writes too much");
    chk_branch_align: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_br && !fetch.addr[0] |=> !wb.pc[0])
        else $error("branch target unaligned");
    chk_branch_cycles: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_br |=> busy [*2] ##1 !busy)
        else $error("branch cycle count wrong");

    // long branch halves, linked only through the link register
    chk_upper_link: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_upper |=> wb.lr_we && !wb.pc_we
        && wb.lr == $past(fetch.addr) + 32'h4
        + {{9{$past(fetch.opcode[10])}}, $past(fetch.opcode[10:0]), 12'h000})
        else $error("upper part link wrong");
    chk_upper_back: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_upper && fetch.opcode[10] |=> wb.lr - $past(fetch.addr) - 32'h4 >= 32'hFFC0_0000)
        else $error("upper part sign wrong");
    chk_upper_fwd: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_upper && !fetch.opcode[10] |=> wb.lr - $past(fetch.addr) - 32'h4 <= 32'h003F_F000)
        else $error("upper part reach wrong");
    chk_upper_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_upper |=> !busy && !wb.psr_we && !wb.saved_program_status_we)
        else $error("upper part stalled");
    chk_lower_pc: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_lower |=> wb.pc_we && wb.pc == $past(link_register)
        + {20'h0, $past(fetch.opcode[10:0]), 1'b0})
        else $error("lower part target wrong");
    chk_lower_fwd: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_lower |=> wb.pc - $past(link_register) <= 32'h0000_0FFE)
        else $error("lower part reach wrong");
    chk_lower_link: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_lower |=> wb.lr_we && wb.lr == ($past(fetch.addr) + 32'h2 | 32'h1))
        else $error("return link wrong");
    chk_lower_odd: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_lower |=> wb.lr[0] && !wb.psr_we && !wb.saved_program_status_we)
        else $error("return link even");
    chk_lower_cycles: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_lower |=> busy [*2] ##1 !busy)
        else $error("lower part cycle count wrong");
    // relies on the register file forwarding the upper write to the lower half
    chk_pair_offset: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take_upper ##1 take_lower |=> wb.pc == $past(fetch.addr, 2) + 32'h4
        + {{9{$past(fetch.opcode[10], 2)}}, $past(fetch.opcode[10:0], 2),
        $past(fetch.opcode[10:0]), 1'b0})
        else $error("long branch pair offset wrong");

    // nothing taken, nothing written
    chk_unknown_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fetch.valid && fetch_ready && op == cbx_pkg::CBX_OP_NONE
        |=> !busy && !wb.pc_we && !wb.lr_we)
        else $error("unknown opcode acted on");
    chk_idle_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !take |=> !wb.pc_we && !wb.lr_we && !wb.psr_we && !wb.saved_program_status_we)
        else $error("write-back without take");
    chk_pc_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wb.pc_we |=> !wb.pc_we)
        else $error("counter write held");

    cov_trap: cover property (@(posedge sys_clk) take_trap);
    cov_branch: cover property (@(posedge sys_clk) take_br);
    cov_pair: cover property (@(posedge sys_clk) take_upper ##1 take_lower);
    cov_trap_chase: cover property (@(posedge sys_clk) take_trap ##3 take_br);
    cov_unknown: cover property (@(posedge sys_clk) fetch.valid && fetch_ready
        && op == cbx_pkg::CBX_OP_NONE);
endmodule

//--- common/cbx_pkg.sv
// Purpose: shared constants and types for the compressed branch/trap executor
// Assumes: 32-bit addresses, 16-bit compressed opcodes
// Notes: opcode prefixes, vector, mode codes and cycle counts live here
package cbx_pkg;
    localparam int ADDR_W = 32;
    localparam int OP_W = 16;
    localparam int PSR_W = 32;
    // opcode prefixes: trap is 11011111, branch 11100, long branch 1111
    localparam logic [7:0] TRAP_PREFIX = 8'hDF;
    localparam logic [4:0] BR_PREFIX = 5'h1C;
    localparam logic [3:0] LBL_PREFIX = 4'hF;
    localparam int LBL_SEL_BIT = 11;
    localparam int OFFSET_W = 11;
    localparam int TRAP_IMM_W = 8;
    localparam logic [31:0] TRAP_VECTOR = 32'h0000_0008;
    localparam logic [31:0] PREFETCH_OFS = 32'h0000_0004;
    localparam logic [31:0] HALF_STEP = 32'h0000_0002;
    localparam int HIGH_SHIFT = 12;
    localparam int LOW_SHIFT = 1;
    // status layout: mode field, state bit and IRQ mask bit
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 5;
    localparam int STATE_BIT = 5;
    localparam int IRQ_MASK_BIT = 7;
    localparam logic [4:0] SUPERVISOR_MODE = 5'h13;
    // trap takes the same cycles as the 32-bit trap (three-cycle refill)
    localparam int TRAP_CYCLES = 3;
    localparam int BR_CYCLES = 3;
    localparam int LBL_LOW_CYCLES = 3;
    localparam int LBL_HIGH_CYCLES = 1;
    localparam int CNT_W = 2;

    typedef enum logic [2:0]
    {
        CBX_OP_NONE = 3'b000,
        CBX_OP_TRAP = 3'b001,
        CBX_OP_BRANCH = 3'b010,
        CBX_OP_LBL_HIGH = 3'b011,
        CBX_OP_LBL_LOW = 3'b100
    } cbx_op_t;

    typedef struct packed
    {
        logic valid;
        logic [15:0] opcode;
        logic [31:0] addr;
    } cbx_fetch_t;

    typedef struct packed
    {
        logic pc_we;
        logic [31:0] pc;
        logic lr_we;
        logic [31:0] lr;
        logic psr_we;
        logic [31:0] cur_psr;
        logic saved_program_status_we;
        logic [31:0] saved_psr;
    } cbx_wb_t;
endpackage

//--- rtl/cbx_decode.sv
// Purpose: classify a compressed opcode and extract its offset field
// Assumes: opcode from the fetch stage, same clock domain
// Notes: pure combinational, no state
`timescale 1ns/100ps
module cbx_decode
(
    input wire logic [15:0] opcode,
    output cbx_pkg::cbx_op_t op,
    output logic [10:0] offset_field
);
    // fixed prefixes pick the instruction class
    always_comb
    begin
        offset_field = opcode[cbx_pkg::OFFSET_W-1:0];
        if (opcode[15:8] == cbx_pkg::TRAP_PREFIX)
            op = cbx_pkg::CBX_OP_TRAP;
        else if (opcode[15:11] == cbx_pkg::BR_PREFIX)
            op = cbx_pkg::CBX_OP_BRANCH;
        else if (opcode[15:12] == cbx_pkg::LBL_PREFIX)
            op = opcode[cbx_pkg::LBL_SEL_BIT] ? cbx_pkg::CBX_OP_LBL_LOW
                                             : cbx_pkg::CBX_OP_LBL_HIGH;
        else
            op = cbx_pkg::CBX_OP_NONE;
    end
endmodule

//--- tb/cbx_fetch_model.sv
// Purpose: fetch stage model offering compressed opcodes to the executor
// Assumes: executor takes an opcode at a rising edge while fetch_ready is high
// Notes: released lines show the inverse so a stale opcode never looks fresh
`timescale 1ns/100ps
module cbx_fetch_model
(
    input wire logic sys_clk,
    input wire logic fetch_ready,
    output cbx_pkg::cbx_fetch_t fetch
);
    initial fetch = '0;

    // hold the offer until the edge that takes it; bounded wait on a stall
    task automatic issue(input logic [15:0] op, input logic [31:0] addr);
        int n;
        n = 0;
        @(negedge sys_clk);
        fetch.valid = 1'b1;
        fetch.opcode = op;
        fetch.addr = addr;
        while (fetch_ready !== 1'b1 && n < 20)
        begin
            @(negedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
    endtask

    // drop valid and scramble the released lines
    task automatic idle();
        @(negedge sys_clk);
        fetch.valid = 1'b0;
        fetch.opcode = ~fetch.opcode;
        fetch.addr = ~fetch.addr;
    endtask
endmodule

//--- tb/compressed_isa_branch_swi_exec_test.sv
// Purpose: self-checking bench for the compressed trap and branch executor
// Assumes: results appear one cycle after the take and stand one cycle
// Notes: expected write-backs are queued by the driver, popped by a monitor
`timescale 1ns/100ps
module compressed_isa_branch_swi_exec_test;
    typedef struct packed {cbx_pkg::cbx_wb_t wb; logic busy;} cbx_note_t;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    cbx_pkg::cbx_fetch_t fetch;
    cbx_pkg::cbx_wb_t wb;
    logic fetch_ready, busy;
    logic [31:0] link_q = 32'h0, link_register, psr = 32'h0, exp_link = 32'h0, a;
    logic [10:0] o;
    logic [10:0] br_edges[5] = '{11'h000, 11'h3FF, 11'h400, 11'h7FF, 11'h001};
    logic [10:0] up_edges[4] = '{11'h7FF, 11'h400, 11'h3FF, 11'h000};
    cbx_note_t notes[$];
    cbx_note_t e;
    int num_errors = 0, compares = 0, seed = 30;

    always #10 sys_clk = ~sys_clk;

    // register file: a link write is forwarded so a back-to-back lower part sees it
    assign link_register = (wb.lr_we === 1'b1) ? wb.lr : link_q;
    always @(posedge sys_clk)
        if (wb.lr_we === 1'b1)
            link_q <= wb.lr;

    cbx_exec cbx_exec_inst (.sys_clk(sys_clk), .rst_n(rst_n), .fetch(fetch),
        .fetch_ready(fetch_ready), .link_register(link_register),
        .current_program_status(psr), .wb(wb), .busy(busy));
    cbx_fetch_model cbx_fetch_model_inst (.sys_clk(sys_clk), .fetch_ready(fetch_ready),
        .fetch(fetch));

    task automatic end_sim();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // work out the write-back from the opcode, note it, then offer the opcode
    task automatic send(input logic [15:0] op, input logic [31:0] ad);
        cbx_note_t n;
        n = '0;
        if (op[15:8] == cbx_pkg::TRAP_PREFIX)
        begin
            @(negedge sys_clk);
            psr = $random(seed);
            n = {1'b1, cbx_pkg::TRAP_VECTOR, 1'b1, ad + 32'h2, 1'b1,
                (psr & 32'hFFFF_FFC0) | 32'h93, 1'b1, psr, 1'b1};
        end
        else if (op[15:11] == cbx_pkg::BR_PREFIX)
            n = {1'b1, ad + 32'h4 + {{20{op[10]}}, op[10:0], 1'b0}, 99'h0, 1'b1};
        else if (op[15:12] == cbx_pkg::LBL_PREFIX && op[11] == 1'b0)
            n = {33'h0, 1'b1, ad + 32'h4 + {{9{op[10]}}, op[10:0], 12'h0}, 66'h0, 1'b0};
        else if (op[15:12] == cbx_pkg::LBL_PREFIX)
            n = {1'b1, exp_link + {20'h0, op[10:0], 1'b0}, 1'b1, ad + 32'h3, 66'h0,
                1'b1};
        if (n.wb.lr_we)
            exp_link = n.wb.lr;
        if (n.wb.pc_we | n.wb.lr_we)
            notes.push_back(n);
        cbx_fetch_model_inst.issue(op, ad);
    endtask

    // monitor: every write-back must match the oldest note, busy included
    always @(negedge sys_clk)
    begin
        if (rst_n === 1'b1 && (wb.pc_we | wb.lr_we | wb.psr_we | wb.saved_program_status_we) === 1'b1)
        begin
            compares++;
            if (notes.size() == 0)
            begin
                num_errors++;
                $display("unexpected at %0t: write-back with nothing expected", $time);
            end
            else
            begin
                e = notes.pop_front();
                if ({wb, busy} !== e)
                begin
                    num_errors++;
                    $display("unexpected at %0t: write-back %h busy %b", $time, wb, busy);
                end
            end
        end
    end

    // watchdog sized well beyond the hundred-odd cycles the sequence needs
    initial
    begin
        #200000;
        num_errors++;
        $display("unexpected at %0t: run did not finish", $time);
        end_sim();
    end

    initial
    begin
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        // unknown prefixes: no write-back, no stall
        send(16'hE800, 32'h100);
        send(16'hDE00, 32'h104);
        // traps with random immediates, each chased by a branch while busy
        repeat (4)
        begin
            a = $random(seed) & 32'hFFFF_FFFE;
            send({cbx_pkg::TRAP_PREFIX, 8'($random(seed))}, a);
            send(16'hE7FE, a + 32'h2);
        end
        // boundary branch offsets, then random ones
        foreach (br_edges[i])
            send({cbx_pkg::BR_PREFIX, br_edges[i]}, 32'h2000);
        repeat (8)
        begin
            o = 11'($random(seed));
            send({cbx_pkg::BR_PREFIX, o}, $random(seed) & 32'hFFFF_FFFE);
        end
        // long branch pairs back to back, extremes of the upper part first
        foreach (up_edges[i])
        begin
            a = $random(seed) & 32'hFFFF_FFFE;
            o = 11'($random(seed));
            send({cbx_pkg::LBL_PREFIX, 1'b0, up_edges[i]}, a);
            send({cbx_pkg::LBL_PREFIX, 1'b1, o}, a + 32'h2);
        end
        cbx_fetch_model_inst.idle();
        repeat (6) @(negedge sys_clk);
        compares++;
        if (notes.size() != 0)
        begin
            num_errors++;
            $display("unexpected at %0t: %0d write-backs missing", $time, notes.size());
        end
        end_sim();
    end
endmodule
